/* File: tdm_emul_pkg.sv */
// Purpose: Shared constants and carriers for the unstructured line circuit emulation block
// Assumes: 25 MHz system clock, 32-bit register port
// Notes: Line rates and the starvation time are held in their own units
package tdm_emul_pkg;
    localparam int CLK_KHZ = 25000;
    localparam int DS1_KBPS = 1544;
    localparam int E1_KBPS = 2048;
    localparam int NCO_W = 24;
    localparam logic [NCO_W-1:0] NCO_DS1 = NCO_W'((64'(DS1_KBPS) << NCO_W) / 64'(CLK_KHZ));
    localparam logic [NCO_W-1:0] NCO_E1 = NCO_W'((64'(E1_KBPS) << NCO_W) / 64'(CLK_KHZ));
    localparam int STARVE_MS = 2500;
    localparam int STARVE_CYC = STARVE_MS * (CLK_KHZ / 1000) * 1000;
    localparam int LOS_BITS = 175;
    localparam logic [8:0] FRAME_BITS_DS1 = 9'd193;
    localparam logic [8:0] FRAME_BITS_E1 = 9'd256;
    localparam logic [7:0] FILL_OCTET = 8'hff;
    localparam logic [7:0] LINK_FLAG = 8'h7e;
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STICKY = 8'h04;
    localparam logic [7:0] ADDR_LIVE = 8'h08;
    localparam logic [7:0] ADDR_OVF_CNT = 8'h0c;
    localparam logic [7:0] ADDR_UNF_CNT = 8'h10;
    localparam logic [7:0] ADDR_MON_MSG = 8'h14;
    localparam int CTRL_MON_EN = 0;
    localparam int CTRL_ASYNC = 1;
    localparam int CTRL_E1 = 2;
    localparam logic [2:0] CTRL_RESET = 3'h0;
    localparam int ST_OVF = 0;
    localparam int ST_UNF = 1;
    localparam int ST_STARVE = 2;
    localparam int ST_LOS = 3;
    localparam int ST_RLOS = 4;
    localparam int ST_RFAIL = 5;
    localparam int ST_MON_AIS = 6;
    localparam int STICKY_W = 7;
    typedef struct packed {
        logic valid;
        logic hdr;
        logic [7:0] seq;
        logic loss_of_signal;
        logic rmt_fail;
        logic [7:0] data;
    } beat_t;
    typedef struct packed {
        logic fill;
        logic [15:0] val;
    } entry_t;
endpackage : tdm_emul_pkg

/* File: bit_sync.sv */
// Purpose: Two-flop synchroniser with rising-edge detect on bit 0
// Assumes: Inputs asynchronous to clk_i
// Notes: The first stage feeds only the second stage
module bit_sync #(
    parameter int W = 1
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o,
    output logic rise_o
);
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic s3;

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            s1 <= '0;
            s2 <= '0;
            s3 <= 1'b0;
        end else begin
            s1 <= d_i;
            s2 <= s1;
            s3 <= s2[0];
        end
    end

    assign q_o = s2;
    assign rise_o = s2[0] & ~s3;
endmodule : bit_sync

/* File: line_monitor.sv */
// Purpose: Non-intrusive framing monitor on the ingress line bits
// Assumes: Frame position counts from the first bit after enable; no alignment hunt
// Notes: Reads the stream only, so the carried bits can never be altered here
module line_monitor
    import tdm_emul_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic en_i,
    input wire logic strobe_i,
    input wire logic bit_i,
    input wire logic [8:0] frame_len_i,
    output logic ais_o,
    output logic msg_o
);
    logic [8:0] pos;
    logic [8:0] ones;
    logic odd;
    logic [7:0] link;

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            pos <= '0;
            ones <= '0;
            odd <= 1'b0;
            link <= '0;
            msg_o <= 1'b0;
        end else if (!en_i) begin
            pos <= '0;
            ones <= '0;
            odd <= 1'b0;
            link <= '0;
            msg_o <= 1'b0;
        end else begin
            msg_o <= 1'b0;
            if (strobe_i) begin
                pos <= (pos == frame_len_i - 9'd1) ? 9'd0 : pos + 9'd1;
                if (!bit_i) begin
                    ones <= '0;
                end else if (ones != frame_len_i) begin
                    ones <= ones + 9'd1;
                end
                if (pos == 9'd0) begin
                    odd <= ~odd;
                    // Data link bits ride in every other framing bit
                    if (odd) begin
                        link <= {link[6:0], bit_i};
                        msg_o <= ({link[6:0], bit_i} == LINK_FLAG);
                    end
                end
            end
        end
    end

    // A whole frame of ones is the alarm pattern
    assign ais_o = en_i && (ones == frame_len_i);
endmodule : line_monitor

/* File: tdm_emul_top.sv */
// Purpose: Unstructured line circuit emulation, ingress packetiser and egress playout
// Assumes: Packet side on CLK_I; line and recovered clocks sampled; DEPTH a power of two
// Notes: Sequence numbers are 8 bits; a header beat opens every packet
// Behaviour
// - Carry any bit stream at line rate, framing ignored
// - Optional monitor decodes framing without touching the stream
// - Control bit switches the monitor off for unframed lines
// - Clocking mode chosen by control; both peers must match
// - Synchronous mode: device drives line timing out
// - Asynchronous mode: customer timing carried, far end replays it
// - Accept customer timing within ppm tolerance of nominal
// - Maintenance link bits pass unchanged
// - Enabled monitor counts data link messages for management
// - Ingress alarms reappear at egress unmodified
// - Ingress detects loss of signal and tells the peer
// - Monitor alarm status readable by management
// - Late packet replaced by filler of previous payload length
// - Packet arriving after its slot was filled is discarded
// - Persistent starvation signalled back to the peer
// - Out-of-sequence packet discarded, filler inserted
// - Filler keeps exact octet count to save multiframe alignment
// - Underflow drives all ones while data is missing
// - Starvation past integration time raises fault and downstream ALARM_INDICATION_SIGNAL
// - Overflow drops octets
// - Overflow and underflow reported to management
module tdm_emul_top
    import tdm_emul_pkg::*;
#(
    parameter int PAYLOAD_OCTETS = 32,
    parameter int DEPTH = 16,
    parameter int STARVE_LIMIT = STARVE_CYC
) (
    input wire logic CLK_I,
    input wire logic RST_I,
    input wire logic LINE_CLK_I,
    input wire logic LINE_DATA_I,
    input wire logic REC_CLK_I,
    output logic TX_CLK_O,
    output logic TX_DATA_O,
    output logic AIS_O,
    output tdm_emul_pkg::beat_t PKT_TX_O,
    input tdm_emul_pkg::beat_t PKT_RX_I,
    input wire logic [7:0] REG_ADDR_I,
    input wire logic [31:0] REG_WDATA_I,
    input wire logic REG_WE_I,
    input wire logic REG_RE_I,
    output logic [31:0] REG_RDATA_O
);
    import tdm_emul_pkg::*;

    localparam int AW = $clog2(DEPTH);

    function automatic logic [15:0] sat_inc(input logic [15:0] v);
        sat_inc = (v == 16'hffff) ? v : v + 16'h0001;
    endfunction : sat_inc

    function automatic logic [AW:0] ptr_inc(input logic [AW:0] p);
        ptr_inc = p + (AW+1)'(1);
    endfunction : ptr_inc

    logic [1:0] line_q;
    logic line_edge;
    logic line_bit;
    logic [0:0] rec_q;
    logic rec_edge;
    logic [2:0] ctrl;
    logic mon_en;
    logic async_mode;
    logic mon_ais;
    logic mon_msg;

    assign mon_en = ctrl[CTRL_MON_EN];
    assign async_mode = ctrl[CTRL_ASYNC];

    // Any clock within tolerance is taken: every sampled edge carries one bit
    bit_sync #(.W(2)) u_line_sync (
        .clk_i(CLK_I),
        .rst_i(RST_I),
        .d_i({LINE_DATA_I, LINE_CLK_I}),
        .q_o(line_q),
        .rise_o(line_edge)
    );
    assign line_bit = line_q[1];

    bit_sync #(.W(1)) u_rec_sync (
        .clk_i(CLK_I),
        .rst_i(RST_I),
        .d_i(REC_CLK_I),
        .q_o(rec_q),
        .rise_o(rec_edge)
    );

    line_monitor u_mon (
        .clk_i(CLK_I),
        .rst_i(RST_I),
        .en_i(mon_en),
        .strobe_i(line_edge),
        .bit_i(line_bit),
        .frame_len_i(ctrl[CTRL_E1] ? FRAME_BITS_E1 : FRAME_BITS_DS1),
        .ais_o(mon_ais),
        .msg_o(mon_msg)
    );

    // Ingress packetiser
    logic [6:0] sh;
    logic [2:0] bit_cnt;
    logic [7:0] oct_cnt;
    logic [7:0] tx_seq;
    logic [7:0] zero_run;
    logic los_live;
    logic starve_fault;
    logic [7:0] in_oct;

    assign in_oct = {sh, line_bit};

    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            sh <= '0;
            bit_cnt <= '0;
            oct_cnt <= '0;
            tx_seq <= '0;
            PKT_TX_O <= '0;
        end else begin
            PKT_TX_O.valid <= 1'b0;
            if (line_edge) begin
                sh <= in_oct[6:0];
                bit_cnt <= bit_cnt + 3'd1;
                if (bit_cnt == 3'd0 && oct_cnt == 8'd0) begin
                    PKT_TX_O.valid <= 1'b1;
                    PKT_TX_O.hdr <= 1'b1;
                    PKT_TX_O.seq <= tx_seq;
                    PKT_TX_O.loss_of_signal <= los_live;
                    PKT_TX_O.rmt_fail <= starve_fault;
                end
                if (bit_cnt == 3'd7) begin
                    // Octets go out bit for bit, alarms and link bits included
                    PKT_TX_O.valid <= 1'b1;
                    PKT_TX_O.hdr <= 1'b0;
                    PKT_TX_O.data <= in_oct;
                    if (oct_cnt == 8'(PAYLOAD_OCTETS - 1)) begin
                        oct_cnt <= '0;
                        tx_seq <= tx_seq + 8'd1;
                    end else begin
                        oct_cnt <= oct_cnt + 8'd1;
                    end
                end
            end
        end
    end

    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            zero_run <= '0;
        end else if (line_edge) begin
            if (line_bit) begin
                zero_run <= '0;
            end else if (zero_run != 8'(LOS_BITS)) begin
                zero_run <= zero_run + 8'd1;
            end
        end
    end
    assign los_live = (zero_run == 8'(LOS_BITS));

    // Egress receive and reorder check
    logic hdr_in;
    logic dat_in;
    logic [7:0] exp_seq;
    logic [7:0] diff;
    logic [7:0] cur_len;
    logic [7:0] last_len;
    logic [7:0] prev_len;
    logic discard;
    logic rlos_live;
    logic rfail_live;
    logic wr_en;
    entry_t wr_entry;

    always_comb begin
        hdr_in = PKT_RX_I.valid & PKT_RX_I.hdr;
        dat_in = PKT_RX_I.valid & ~PKT_RX_I.hdr;
        diff = PKT_RX_I.seq - exp_seq;
        prev_len = (cur_len != 8'h00) ? cur_len : last_len;
        wr_en = 1'b0;
        wr_entry = '0;
        if (hdr_in && diff != 8'h00 && !diff[7]) begin
            // One entry stands for the whole gap, same octet count as lost data
            wr_en = 1'b1;
            wr_entry.fill = 1'b1;
            wr_entry.val = 16'(diff) * 16'(prev_len);
        end else if (dat_in && !discard) begin
            wr_en = 1'b1;
            wr_entry.val = {8'h00, PKT_RX_I.data};
        end
    end

    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            exp_seq <= '0;
            cur_len <= '0;
            last_len <= 8'(PAYLOAD_OCTETS);
            discard <= 1'b0;
            rlos_live <= 1'b0;
            rfail_live <= 1'b0;
        end else if (hdr_in) begin
            rlos_live <= PKT_RX_I.loss_of_signal;
            rfail_live <= PKT_RX_I.rmt_fail;
            if (diff[7]) begin
                // Its slot is already played or filled
                discard <= 1'b1;
            end else begin
                discard <= 1'b0;
                exp_seq <= PKT_RX_I.seq + 8'd1;
                last_len <= prev_len;
                cur_len <= '0;
            end
        end else if (dat_in && !discard) begin
            cur_len <= cur_len + 8'd1;
        end
    end

    // Playout buffer
    entry_t mem [DEPTH];
    logic [AW:0] wp;
    logic [AW:0] rp;
    logic full;
    logic empty;
    logic rd_en;
    logic ovf_ev;
    entry_t rd_entry;

    assign empty = (wp == rp);
    assign full = (wp[AW] != rp[AW]) && (wp[AW-1:0] == rp[AW-1:0]);
    assign rd_entry = mem[rp[AW-1:0]];
    // A write into a full buffer is simply lost
    assign ovf_ev = wr_en && full;

    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            wp <= '0;
            rp <= '0;
        end else begin
            if (wr_en && !full) begin
                wp <= ptr_inc(wp);
            end
            if (rd_en) begin
                rp <= ptr_inc(rp);
            end
        end
    end

    always_ff @(posedge CLK_I) begin
        if (wr_en && !full) begin
            mem[wp[AW-1:0]] <= wr_entry;
        end
    end

    // Egress timing and bit playout
    logic [NCO_W-1:0] nco;
    logic nco_msb_d;
    logic out_strobe;
    logic [6:0] osh;
    logic [2:0] ob_cnt;
    logic [15:0] fill_left;
    logic load;
    logic starving;
    logic unf_ev;
    logic [31:0] starve_cnt;

    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            nco <= '0;
            nco_msb_d <= 1'b0;
            TX_CLK_O <= 1'b0;
        end else begin
            nco <= nco + (ctrl[CTRL_E1] ? NCO_E1 : NCO_DS1);
            nco_msb_d <= nco[NCO_W-1];
            TX_CLK_O <= async_mode ? rec_q[0] : nco[NCO_W-1];
        end
    end

    assign out_strobe = async_mode ? rec_edge : (nco[NCO_W-1] & ~nco_msb_d);
    assign load = out_strobe && (ob_cnt == 3'd0);
    assign rd_en = load && (fill_left == 16'h0000) && !empty;
    assign unf_ev = load && (fill_left == 16'h0000) && empty && !starving;

    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            osh <= '0;
            ob_cnt <= '0;
            fill_left <= '0;
            starving <= 1'b0;
            TX_DATA_O <= 1'b1;
        end else if (load) begin
            ob_cnt <= 3'd7;
            if (fill_left != 16'h0000) begin
                fill_left <= fill_left - 16'h0001;
                osh <= FILL_OCTET[6:0];
                TX_DATA_O <= 1'b1;
            end else if (empty) begin
                starving <= 1'b1;
                osh <= FILL_OCTET[6:0];
                TX_DATA_O <= 1'b1;
            end else if (rd_entry.fill) begin
                starving <= 1'b0;
                fill_left <= (rd_entry.val == 16'h0000) ? 16'h0000 : rd_entry.val - 16'h0001;
                osh <= FILL_OCTET[6:0];
                TX_DATA_O <= 1'b1;
            end else begin
                starving <= 1'b0;
                osh <= rd_entry.val[6:0];
                TX_DATA_O <= rd_entry.val[7] | starve_fault | rlos_live;
            end
        end else if (out_strobe) begin
            ob_cnt <= ob_cnt - 3'd1;
            osh <= {osh[5:0], 1'b1};
            TX_DATA_O <= osh[6] | starve_fault | rlos_live;
        end else if (starve_fault) begin
            TX_DATA_O <= 1'b1;
        end
    end

    // Integration timer; fault holds until data flows again
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            starve_cnt <= '0;
            starve_fault <= 1'b0;
            AIS_O <= 1'b0;
        end else begin
            if (!starving) begin
                starve_cnt <= '0;
                starve_fault <= 1'b0;
            end else if (starve_cnt == 32'(STARVE_LIMIT - 1)) begin
                starve_fault <= 1'b1;
            end else begin
                starve_cnt <= starve_cnt + 32'd1;
            end
            AIS_O <= starve_fault | rlos_live;
        end
    end

    // Management registers
    logic [STICKY_W-1:0] sticky;
    logic [STICKY_W-1:0] next_sticky;
    logic [STICKY_W-1:0] set_vec;
    logic [STICKY_W-1:0] clr_vec;
    logic [15:0] ovf_cnt;
    logic [15:0] unf_cnt;
    logic [15:0] mon_msg_cnt;

    always_comb begin
        set_vec = '0;
        set_vec[ST_OVF] = ovf_ev;
        set_vec[ST_UNF] = unf_ev;
        set_vec[ST_STARVE] = starve_fault;
        set_vec[ST_LOS] = los_live;
        set_vec[ST_RLOS] = rlos_live;
        set_vec[ST_RFAIL] = rfail_live;
        set_vec[ST_MON_AIS] = mon_ais;
        clr_vec = (REG_WE_I && REG_ADDR_I == ADDR_STICKY) ? REG_WDATA_I[STICKY_W-1:0] : '0;
        // A new event in the clearing cycle survives the clear
        next_sticky = (sticky & ~clr_vec) | set_vec;
    end

    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            ctrl <= CTRL_RESET;
            sticky <= '0;
        end else begin
            sticky <= next_sticky;
            if (REG_WE_I && REG_ADDR_I == ADDR_CTRL) begin
                ctrl <= REG_WDATA_I[2:0];
            end
        end
    end

    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            ovf_cnt <= '0;
            unf_cnt <= '0;
            mon_msg_cnt <= '0;
        end else begin
            if (ovf_ev) begin
                ovf_cnt <= sat_inc(ovf_cnt);
            end
            if (unf_ev) begin
                unf_cnt <= sat_inc(unf_cnt);
            end
            if (mon_msg && mon_en) begin
                mon_msg_cnt <= sat_inc(mon_msg_cnt);
            end
        end
    end

    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            REG_RDATA_O <= '0;
        end else begin
            REG_RDATA_O <= '0;
            if (REG_RE_I) begin
                case (REG_ADDR_I)
                    ADDR_CTRL: REG_RDATA_O <= {29'h0, ctrl};
                    ADDR_STICKY: REG_RDATA_O <= {25'h0, sticky};
                    ADDR_LIVE: REG_RDATA_O <= {25'h0, mon_ais, rfail_live, rlos_live,
                                               los_live, starve_fault, starving, full};
                    ADDR_OVF_CNT: REG_RDATA_O <= {16'h0, ovf_cnt};
                    ADDR_UNF_CNT: REG_RDATA_O <= {16'h0, unf_cnt};
                    ADDR_MON_MSG: REG_RDATA_O <= {16'h0, mon_msg_cnt};
                    default: REG_RDATA_O <= '0;
                endcase
            end
        end
    end

    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (RST_I);

    sequence s_gap_hdr;
        hdr_in && diff != 8'h00 && !diff[7];
    endsequence
    sequence s_late_hdr;
        hdr_in && diff[7];
    endsequence
    sequence s_starve_load;
        load && fill_left == 16'h0000 && empty;
    endsequence

    a_gap_filler: assert property (s_gap_hdr |-> wr_en && wr_entry.fill && wr_entry.val == 16'(diff) * 16'(prev_len))
        else $error("gap filler length wrong");
    a_late_drop: assert property (s_late_hdr ##1 dat_in |-> !wr_en)
        else $error("late packet data was written");
    a_ovf_flag: assert property (wr_en && full |=> sticky[ST_OVF] && $stable(wp))
        else $error("overflow not flagged or not dropped");
    a_unf_flag: assert property ($rose(starving) |-> sticky[ST_UNF])
        else $error("underflow not flagged");
    a_starve_ones: assert property (s_starve_load |=> TX_DATA_O && starving)
        else $error("starvation output not all ones");
    a_starve_fault: assert property (starving && starve_cnt == 32'(STARVE_LIMIT - 1) |=> starve_fault)
        else $error("starvation fault late");
    a_ais_force: assert property (starve_fault |=> TX_DATA_O && AIS_O)
        else $error("downstream alarm missing");
    a_los_raise: assert property (line_edge && !line_bit && zero_run == 8'(LOS_BITS - 1) |=> los_live)
        else $error("loss of signal not raised");
    a_data_pass: assert property (line_edge && bit_cnt == 3'd7 |=> PKT_TX_O.valid && PKT_TX_O.data == $past(in_oct))
        else $error("line octet altered");
    a_mon_idle: assert property (!mon_en |=> $stable(mon_msg_cnt))
        else $error("monitor counted while disabled");
    a_sticky_keep: assert property (sticky[ST_OVF] && !clr_vec[ST_OVF] |=> sticky[ST_OVF])
        else $error("sticky flag lost");
endmodule : tdm_emul_top

/* File: line_src.sv */
// Purpose: Customer line equipment driving the ingress line, MSB first
// Assumes: 320 ns bit period
// Notes: Clock stands still between bursts; idle data shows the inverse of the last bit
module line_src;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic dat = 1'b1;
    task automatic send_byte(input logic [7:0] b);
        for (int i = 7; i >= 0; i--) begin
            dat = b[i];
            #160 clk = 1'b1;
            #160 clk = 1'b0;
        end
        dat = ~b[0];
    endtask : send_byte
endmodule : line_src

/* File: unstructured_tdm_circuit_emulation_tb_top.sv */
// Purpose: Self-checking bench for the line circuit emulation block
// Assumes: Short payload and starvation limit to keep the run brief
// Notes: The recovered clock toggles only in the clock scenario; sync mode elsewhere, except where the control register sweep writes async values
module unstructured_tdm_circuit_emulation_tb_top import tdm_emul_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int PO = 4;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] reg_addr = '0;
    logic [31:0] reg_wdata = '0;
    logic reg_we = 1'b0;
    logic reg_re = 1'b0;
    logic [31:0] reg_rdata;
    beat_t pkt_rx = '0;
    beat_t pkt_tx;
    logic tx_data;
    logic alarm_indication_signal;
    logic rec_clk = 1'b0;
    logic tx_clk;
    logic tx_clk_d = 1'b0;
    int clk_edges = 0;
    int mismatches = 0;
    int num_checks = 0;
    beat_t q[$];
    logic [7:0] bytes[PO] = '{8'h7e, 8'ha5, 8'h00, 8'hc3};
    line_src i_src();
    tdm_emul_top #(.PAYLOAD_OCTETS(PO), .DEPTH(16), .STARVE_LIMIT(200)) i_dut (
        .CLK_I(clk), .RST_I(rst), .LINE_CLK_I(i_src.clk), .LINE_DATA_I(i_src.dat),
        .REC_CLK_I(rec_clk), .TX_CLK_O(tx_clk), .TX_DATA_O(tx_data), .AIS_O(alarm_indication_signal),
        .PKT_TX_O(pkt_tx), .PKT_RX_I(pkt_rx), .REG_ADDR_I(reg_addr),
        .REG_WDATA_I(reg_wdata), .REG_WE_I(reg_we), .REG_RE_I(reg_re),
        .REG_RDATA_O(reg_rdata));
    always #20 clk = ~clk;
    always @(posedge clk) begin
        if (pkt_tx.valid === 1'b1) q.push_back(pkt_tx);
    end
    always @(posedge clk) begin
        tx_clk_d <= tx_clk;
        if (tx_clk === 1'b1 && tx_clk_d === 1'b0) clk_edges <= clk_edges + 1;
    end
    task automatic wrap_up;
        if (mismatches == 0 && num_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : wrap_up
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_we <= 1'b1;
        @(posedge clk);
        reg_we <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_re <= 1'b1;
        @(posedge clk);
        reg_re <= 1'b0;
        #1 d = reg_rdata;
    endtask : rd
    task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] m, e);
        logic [31:0] v;
        rd(a, v);
        chk(nm, v & m, e);
    endtask : rdchk
    task automatic beat(input logic h, input logic [7:0] s, input logic [7:0] d);
        @(posedge clk);
        pkt_rx <= '{1'b1, h, s, 1'b0, 1'b0, d};
    endtask : beat
    task automatic t_ctrl;
        rdchk("ctrl_rst", ADDR_CTRL, '1, 32'h0);
        for (int m = 0; m < 8; m++) begin
            wr(ADDR_CTRL, 32'(m));
            rdchk("ctrl", ADDR_CTRL, '1, 32'(m));
        end
        wr(ADDR_CTRL, 32'h0);
        rdchk("unmapped", 8'h40, '1, 32'h0);
    endtask : t_ctrl
    task automatic t_clk;
        int n0;
        int lo;
        n0 = clk_edges;
        lo = 2500 * DS1_KBPS / CLK_KHZ;
        repeat (2500) @(posedge clk);
        chk("tx_clk_ds1", 32'(clk_edges - n0 == lo || clk_edges - n0 == lo + 1), 32'h1);
        wr(ADDR_CTRL, 32'(1) << CTRL_ASYNC);
        // Let the mode switch settle so no leftover edge is counted
        repeat (4) @(posedge clk);
        n0 = clk_edges;
        repeat (10) begin
            rec_clk <= 1'b1;
            repeat (4) @(posedge clk);
            rec_clk <= 1'b0;
            repeat (4) @(posedge clk);
        end
        chk("tx_clk_async", 32'(clk_edges - n0), 32'd10);
        wr(ADDR_CTRL, 32'h0);
    endtask : t_clk
    task automatic t_ingress;
        q.delete();
        for (int i = 0; i < PO; i++) i_src.send_byte(bytes[i]);
        repeat (8) @(posedge clk);
        chk("beats", 32'(q.size()), 32'(PO + 1));
        chk("hdr", {q[0].hdr, q[0].seq}, {1'b1, 8'h00});
        chk("hdr_flags", {q[0].loss_of_signal, q[0].rmt_fail}, 2'b01);
        for (int i = 0; i < PO; i++) chk("data", q[i + 1].data, bytes[i]);
    endtask : t_ingress
    task automatic t_los;
        repeat (24) i_src.send_byte(8'h00);
        repeat (8) @(posedge clk);
        rdchk("los_live", ADDR_LIVE, 32'(1) << ST_LOS, 32'(1) << ST_LOS);
        q.delete();
        i_src.send_byte(8'hff);
        repeat (8) @(posedge clk);
        chk("hdr_los", 32'(q[0].loss_of_signal), 32'h1);
        rdchk("los_gone", ADDR_LIVE, 32'(1) << ST_LOS, 32'h0);
        rdchk("los_sticky", ADDR_STICKY, 32'(1) << ST_LOS, 32'(1) << ST_LOS);
        wr(ADDR_STICKY, 32'(1) << ST_LOS);
        rdchk("los_clr", ADDR_STICKY, 32'(1) << ST_LOS, 32'h0);
    endtask : t_los
    task automatic t_mon;
        wr(ADDR_CTRL, 32'(1) << CTRL_MON_EN);
        repeat (25) i_src.send_byte(8'hff);
        repeat (8) @(posedge clk);
        rdchk("mon_ais", ADDR_LIVE, 32'(1) << ST_MON_AIS, 32'(1) << ST_MON_AIS);
        wr(ADDR_CTRL, 32'h0);
        rdchk("mon_off", ADDR_LIVE, 32'(1) << ST_MON_AIS, 32'h0);
    endtask : t_mon
    task automatic t_starve;
        chk("ais", 32'(alarm_indication_signal), 32'h1);
        chk("tx_ones", 32'(tx_data), 32'h1);
        rdchk("starving", ADDR_LIVE, 32'h6, 32'h6);
        rdchk("unf_sticky", ADDR_STICKY, 32'h6, 32'h6);
    endtask : t_starve
    task automatic t_ovf;
        logic [31:0] c0;
        logic [31:0] c1;
        // Sequence 0 arrives only later: a filler entry takes the first slot
        beat(1'b1, 8'h01, 8'h00);
        beat(1'b1, 8'h02, 8'h00);
        for (int i = 0; i < 40; i++) beat(1'b0, 8'h00, 8'(i));
        @(posedge clk);
        pkt_rx <= '0;
        rdchk("ovf_sticky", ADDR_STICKY, 32'h1, 32'h1);
        rd(ADDR_OVF_CNT, c0);
        chk("ovf_cnt", 32'(c0 >= 20), 32'h1);
        // Stale header: its beats must be thrown away, not counted as overflow
        beat(1'b1, 8'h00, 8'h00);
        for (int i = 0; i < 4; i++) beat(1'b0, 8'h00, 8'h55);
        @(posedge clk);
        pkt_rx <= '0;
        rd(ADDR_OVF_CNT, c1);
        chk("stale", c1, c0);
    endtask : t_ovf
    initial begin
        #1ms;
        mismatches++;
        wrap_up();
    end
    initial begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        t_ctrl();
        t_clk();
        t_ingress();
        t_los();
        t_mon();
        t_starve();
        t_ovf();
        wrap_up();
    end
endmodule : unstructured_tdm_circuit_emulation_tb_top
